// *** logic/cor_defs.svh ***
// register offsets, field positions, reset values and serial engine constants for the config bank
`ifndef COR_DEFS_SVH
`define COR_DEFS_SVH

// register offsets (command byte values)
`define COR_OFS_DISABLE_STATE  8'h0b
`define COR_OFS_IMP_01         8'h0c
`define COR_OFS_IMP_23         8'h0d
`define COR_OFS_BIAS_01        8'h0e
`define COR_OFS_BIAS_23        8'h0f
`define COR_OFS_PWR_BIAS       8'h10
`define COR_OFS_RSVD_17        8'h11
`define COR_OFS_EN_POL         8'h12
`define COR_OFS_PWR_POL        8'h13

// writable bit masks; every other bit is reserved
`define COR_MASK_DISABLE_STATE 8'h03
`define COR_MASK_PAIR_HI       8'hcc
`define COR_MASK_PAIR_LO       8'h3c
`define COR_MASK_PWR_BIAS      8'h03
`define COR_MASK_EN_POL        8'h6a
`define COR_MASK_PWR_POL       8'h01

// reset values
`define COR_RST_DISABLE_STATE  8'h00
`define COR_RST_IMP_01         8'h44
`define COR_RST_IMP_23         8'h14
`define COR_RST_BIAS_01        8'h44
`define COR_RST_BIAS_23        8'h14
`define COR_RST_PWR_BIAS       8'h00
`define COR_RST_EN_POL         8'h00
`define COR_RST_PWR_POL        8'h00
// reserved bit that reads back as one in the power pin bias byte
`define COR_RSVD_PWR_BIAS      8'h04

// field positions (low bit of each field)
`define COR_POS_IMP1           6
`define COR_POS_IMP0           2
`define COR_POS_IMP3           4
`define COR_POS_IMP2           2
`define COR_POS_EN_POL0        1
`define COR_POS_EN_POL1        3
`define COR_POS_EN_POL2        5
`define COR_POS_EN_POL3        6
`define COR_POS_PWR_POL        0

// serial engine
`define COR_BITS_PER_BYTE      4'd8
`define COR_SYNC_STAGES        2

`endif

// *** logic/cor_pkg.sv ***
// types shared by the clock output config bank
package cor_pkg;

  // disabled output level codes
  typedef enum logic [1:0] {
    COR_DIS_LOW_LOW  = 2'b00,
    COR_DIS_HIZ      = 2'b01,
    COR_DIS_HIGH_LOW = 2'b10,
    COR_DIS_LOW_HIGH = 2'b11
  } cor_dis_t;

  // serial slave states
  typedef enum logic [3:0] {
    COR_ST_IDLE  = 4'b0000,
    COR_ST_ADDR  = 4'b0001,
    COR_ST_AADDR = 4'b0010,
    COR_ST_CMD   = 4'b0011,
    COR_ST_ACMD  = 4'b0100,
    COR_ST_WDATA = 4'b0101,
    COR_ST_AWR   = 4'b0110,
    COR_ST_RDATA = 4'b0111,
    COR_ST_RACK  = 4'b1000
  } cor_state_t;

endpackage : cor_pkg

// *** logic/cor_out_if.sv ***
// carrier between the register bank and the output level decoder
interface cor_out_if;
  logic [3:0] running;
  logic [1:0] disable_level_select;
  logic [3:0] true_lvl;
  logic [3:0] true_oe;
  logic [3:0] comp_lvl;
  logic [3:0] comp_oe;

  modport ctl (output running, output disable_level_select,
               input true_lvl, input true_oe, input comp_lvl, input comp_oe);
  modport drv (input running, input disable_level_select,
               output true_lvl, output true_oe, output comp_lvl, output comp_oe);
endinterface : cor_out_if

// *** logic/cor_sync.sv ***
// two flip-flop synchroniser for pin inputs
module cor_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] din,
  input  wire logic [WIDTH-1:0] rst_val,
  output      logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta_reg <= '0;
      dout     <= '0;
    end
    else
    begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

  // rst_val kept for interface symmetry; flops reset to a constant
  logic unused_rst;
  assign unused_rst = ^rst_val;
endmodule : cor_sync

// *** logic/cor_out_decode.sv ***
// per-output true/complement level decoder for disabled differential clocks
`include "cor_defs.svh"
module cor_out_decode (
  input  wire logic ref_clk,
  input  wire logic rstn,
  cor_out_if.drv    o
);
  import cor_pkg::*;

  logic [3:0] true_lvl_next;
  logic [3:0] true_oe_next;
  logic [3:0] comp_lvl_next;
  logic [3:0] comp_oe_next;
  logic [3:0] true_lvl_reg;
  logic [3:0] true_oe_reg;
  logic [3:0] comp_lvl_reg;
  logic [3:0] comp_oe_reg;

  // running outputs are marked high and driven; disabled ones follow the code
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      true_lvl_next[i] = 1'b1;
      comp_lvl_next[i] = 1'b0;
      true_oe_next[i]  = 1'b1;
      comp_oe_next[i]  = 1'b1;
      if (!o.running[i])
      begin
        case (cor_dis_t'(o.disable_level_select)) // R1
          COR_DIS_LOW_LOW:
          begin
            true_lvl_next[i] = 1'b0;
            comp_lvl_next[i] = 1'b0;
          end
          COR_DIS_HIZ:
          begin
            true_lvl_next[i] = 1'b0;
            comp_lvl_next[i] = 1'b0;
            true_oe_next[i]  = 1'b0;
            comp_oe_next[i]  = 1'b0;
          end
          COR_DIS_HIGH_LOW:
          begin
            true_lvl_next[i] = 1'b1;
            comp_lvl_next[i] = 1'b0;
          end
          default:
          begin
            true_lvl_next[i] = 1'b0;
            comp_lvl_next[i] = 1'b1;
          end
        endcase
      end
    end
  end

  // registered so the pad controls never glitch
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      true_lvl_reg <= 4'h0;
      true_oe_reg  <= 4'hf;
      comp_lvl_reg <= 4'h0;
      comp_oe_reg  <= 4'hf;
    end
    else
    begin
      true_lvl_reg <= true_lvl_next;
      true_oe_reg  <= true_oe_next;
      comp_lvl_reg <= comp_lvl_next;
      comp_oe_reg  <= comp_oe_next;
    end
  end

  assign o.true_lvl = true_lvl_reg;
  assign o.true_oe  = true_oe_reg;
  assign o.comp_lvl = comp_lvl_reg;
  assign o.comp_oe  = comp_oe_reg;

  hiz_state_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
    (!o.running[0] && o.disable_level_select == 2'b01) |=> (!true_oe_reg[0] && !comp_oe_reg[0]))
    else $error("disabled output not released in hiz code");
  low_high_state_a: assert property (@(posedge ref_clk) disable iff (!rstn) // R1
    (!o.running[1] && o.disable_level_select == 2'b11) |=> (!true_lvl_reg[1] && comp_lvl_reg[1]))
    else $error("low/high disable code not driven");
endmodule : cor_out_decode

// *** logic/cor_regs.sv ***
// clock output configuration register bank with its serial management slave
// What this block does
// R1: disable code in byte 11 bits 1:0 sets true/complement levels of disabled clocks
// R2: byte 12 holds impedance codes of outputs 1 and 0, default 85 ohm
// R3: byte 13 holds impedance codes of outputs 3 and 2, default 85 ohm
// R4: byte 14 holds bias codes for enable pins 1 and 0, default pull-down
// R5: byte 15 holds bias codes for enable pins 3 and 2, default pull-down
// R6: byte 16 bits 1:0 select bias on the power-good/power-down pin
// R7: byte 18 holds per-enable-pin polarity bits at 1,3,5,6, default active low
// R8: byte 19 bit 0 sets power-down pin polarity, default power down when low
// R9: disabled reference output level also follows the byte 11 code
// R10: reserved bits and byte 17 ignore writes with no side effects
`include "cor_defs.svh"
module cor_regs #(
  parameter logic [6:0] SLAVE_ADDR = 7'h55 // arbitrary default, set per board
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output      logic       sda_out,
  output      logic       sda_oe,
  input  wire logic [3:0] enable_pin,
  input  wire logic       power_good_powerdown_pin,
  input  wire logic       ref_output_enable,
  output      logic [3:0] clk_true_lvl,
  output      logic [3:0] clk_true_oe,
  output      logic [3:0] clk_comp_lvl,
  output      logic [3:0] clk_comp_oe,
  output      logic       ref_disabled,
  output      logic       ref_dis_lvl,
  output      logic       ref_dis_oe,
  output      logic       power_down,
  output      logic [7:0] output_impedance_select,
  output      logic [3:0] enable_pin_pull_up,
  output      logic [3:0] enable_pin_pull_down,
  output      logic       power_pin_pull_up,
  output      logic       power_pin_pull_down
);
  import cor_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [6:0] pins_s;
  logic       scl_n_s;
  logic       sda_n_s;
  logic       scl_s;
  logic       sda_s;
  logic [3:0] en_s;
  logic       pg_s;

  cor_sync #(.WIDTH(7)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     ({~scl_in, ~sda_in, enable_pin, power_good_powerdown_pin}),
    .rst_val (7'h00),
    .dout    (pins_s)
  );
  // bus pins cross inverted so the zero reset equals their idle high level: no false edge
  assign {scl_n_s, sda_n_s, en_s, pg_s} = pins_s;
  assign scl_s = ~scl_n_s;
  assign sda_s = ~sda_n_s;

  //////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [7:0] dis_reg, dis_next;
  logic [7:0] imp01_reg, imp01_next;
  logic [7:0] imp23_reg, imp23_next;
  logic [7:0] bias01_reg, bias01_next;
  logic [7:0] bias23_reg, bias23_next;
  logic [7:0] pbias_reg, pbias_next;
  logic [7:0] enpol_reg, enpol_next;
  logic [7:0] ppol_reg, ppol_next;
  logic       wr_en;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;

  // read view; reserved bits read zero except the one fixed at one
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    case (a)
      `COR_OFS_DISABLE_STATE: reg_read = dis_reg;
      `COR_OFS_IMP_01:        reg_read = imp01_reg;
      `COR_OFS_IMP_23:        reg_read = imp23_reg;
      `COR_OFS_BIAS_01:       reg_read = bias01_reg;
      `COR_OFS_BIAS_23:       reg_read = bias23_reg;
      `COR_OFS_PWR_BIAS:      reg_read = pbias_reg | `COR_RSVD_PWR_BIAS;
      `COR_OFS_EN_POL:        reg_read = enpol_reg;
      `COR_OFS_PWR_POL:       reg_read = ppol_reg;
      default:                reg_read = 8'h00; // byte 17 and unmapped
    endcase
  endfunction : reg_read

  // masked merge keeps reserved bits at zero
  function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                       input logic [7:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // writes land only in defined fields; byte 17 has no storage
  always_comb
  begin
    dis_next    = dis_reg;
    imp01_next  = imp01_reg;
    imp23_next  = imp23_reg;
    bias01_next = bias01_reg;
    bias23_next = bias23_reg;
    pbias_next  = pbias_reg;
    enpol_next  = enpol_reg;
    ppol_next   = ppol_reg;
    if (wr_en)
    begin
      case (wr_ptr)
        `COR_OFS_DISABLE_STATE: dis_next = merge(dis_reg, wr_data, `COR_MASK_DISABLE_STATE); // R1
        `COR_OFS_IMP_01:  imp01_next  = merge(imp01_reg, wr_data, `COR_MASK_PAIR_HI); // R2
        `COR_OFS_IMP_23:  imp23_next  = merge(imp23_reg, wr_data, `COR_MASK_PAIR_LO); // R3
        `COR_OFS_BIAS_01: bias01_next = merge(bias01_reg, wr_data, `COR_MASK_PAIR_HI); // R4
        `COR_OFS_BIAS_23: bias23_next = merge(bias23_reg, wr_data, `COR_MASK_PAIR_LO); // R5
        `COR_OFS_PWR_BIAS: pbias_next = merge(pbias_reg, wr_data, `COR_MASK_PWR_BIAS); // R6
        `COR_OFS_EN_POL:  enpol_next  = merge(enpol_reg, wr_data, `COR_MASK_EN_POL); // R7
        `COR_OFS_PWR_POL: ppol_next   = merge(ppol_reg, wr_data, `COR_MASK_PWR_POL); // R8
        default:          ppol_next   = ppol_reg; // R10
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dis_reg    <= `COR_RST_DISABLE_STATE;
      imp01_reg  <= `COR_RST_IMP_01;
      imp23_reg  <= `COR_RST_IMP_23;
      bias01_reg <= `COR_RST_BIAS_01;
      bias23_reg <= `COR_RST_BIAS_23;
      pbias_reg  <= `COR_RST_PWR_BIAS;
      enpol_reg  <= `COR_RST_EN_POL;
      ppol_reg   <= `COR_RST_PWR_POL;
    end
    else
    begin
      dis_reg    <= dis_next;
      imp01_reg  <= imp01_next;
      imp23_reg  <= imp23_next;
      bias01_reg <= bias01_next;
      bias23_reg <= bias23_next;
      pbias_reg  <= pbias_next;
      enpol_reg  <= enpol_next;
      ppol_reg   <= ppol_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serial slave: address, command byte, then auto-incrementing data bytes

  cor_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic       drv_reg, drv_next;
  logic       nack_reg, nack_next;
  logic       scl_d_reg, sda_d_reg;
  logic       scl_rise, scl_fall, start_c, stop_c, last_bit;
  logic [7:0] rd_cur, rd_inc;

  // read bytes at the pointer and the one after; a process so register changes are seen
  always_comb
  begin
    rd_cur = reg_read(ptr_reg);
    rd_inc = reg_read(ptr_reg + 8'd1);
  end

  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_c  = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_c   = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  assign last_bit = (cnt_reg == `COR_BITS_PER_BYTE);

  // bit sequencing; start and stop override any state
  always_comb
  begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    sh_next   = sh_reg;
    ptr_next  = ptr_reg;
    drv_next  = drv_reg;
    nack_next = nack_reg;
    wr_en     = 1'b0;
    if (start_c)
    begin
      st_next  = COR_ST_ADDR;
      cnt_next = 4'd0;
      drv_next = 1'b0;
    end
    else if (stop_c)
    begin
      st_next  = COR_ST_IDLE;
      drv_next = 1'b0;
    end
    else
    begin
      case (st_reg)
        COR_ST_ADDR, COR_ST_CMD, COR_ST_WDATA:
        begin
          if (scl_rise)
          begin
            sh_next  = {sh_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'd1;
          end
          else if (scl_fall && last_bit)
          begin
            drv_next = 1'b1;
            if (st_reg == COR_ST_ADDR)
            begin
              // foreign address: stay off the bus until the next start
              if (sh_reg[7:1] == SLAVE_ADDR)
                st_next = COR_ST_AADDR;
              else
              begin
                st_next  = COR_ST_IDLE;
                drv_next = 1'b0;
              end
              nack_next = sh_reg[0];
            end
            else if (st_reg == COR_ST_CMD)
            begin
              ptr_next = sh_reg;
              st_next  = COR_ST_ACMD;
            end
            else
            begin
              wr_en   = 1'b1;
              st_next = COR_ST_AWR;
            end
          end
        end
        COR_ST_AADDR, COR_ST_ACMD, COR_ST_AWR:
        begin
          if (scl_fall)
          begin
            cnt_next = 4'd0;
            drv_next = 1'b0;
            if (st_reg == COR_ST_AWR)
              ptr_next = ptr_reg + 8'd1;
            if (st_reg == COR_ST_AADDR && nack_reg)
            begin
              // read direction: first data bit goes out now
              sh_next  = rd_cur;
              drv_next = !rd_cur[7];
              st_next  = COR_ST_RDATA;
            end
            else if (st_reg == COR_ST_AADDR)
              st_next = COR_ST_CMD;
            else
              st_next = COR_ST_WDATA;
          end
        end
        COR_ST_RDATA:
        begin
          if (scl_rise)
            cnt_next = cnt_reg + 4'd1;
          else if (scl_fall)
          begin
            if (last_bit)
            begin
              drv_next = 1'b0;
              st_next  = COR_ST_RACK;
            end
            else
            begin
              sh_next  = {sh_reg[6:0], 1'b0};
              drv_next = !sh_reg[6];
            end
          end
        end
        COR_ST_RACK:
        begin
          if (scl_rise)
            nack_next = sda_s;
          else if (scl_fall)
          begin
            cnt_next = 4'd0;
            ptr_next = ptr_reg + 8'd1;
            if (nack_reg)
              st_next = COR_ST_IDLE;
            else
            begin
              sh_next  = rd_inc;
              drv_next = !rd_inc[7];
              st_next  = COR_ST_RDATA;
            end
          end
        end
        default: st_next = COR_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg    <= COR_ST_IDLE;
      cnt_reg   <= 4'd0;
      sh_reg    <= 8'h00;
      ptr_reg   <= 8'h00;
      drv_reg   <= 1'b0;
      nack_reg  <= 1'b0;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else
    begin
      st_reg    <= st_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      ptr_reg   <= ptr_next;
      drv_reg   <= drv_next;
      nack_reg  <= nack_next;
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  assign wr_ptr  = ptr_reg;
  assign wr_data = sh_reg;
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = drv_reg;

  //////////////////////////////////////////////////////////////////////////////
  // output control

  logic [3:0] en_pol;
  logic [3:0] enabled;
  logic       pd_c;
  logic [7:0] ctl_next, ctl_reg;

  // polarity bit set means the pin enables when high
  assign en_pol = {enpol_reg[`COR_POS_EN_POL3], enpol_reg[`COR_POS_EN_POL2],
                   enpol_reg[`COR_POS_EN_POL1], enpol_reg[`COR_POS_EN_POL0]}; // R7
  assign enabled = ~(en_s ^ en_pol); // R7
  assign pd_c    = (pg_s == ppol_reg[`COR_POS_PWR_POL]); // R8

  cor_out_if oif ();
  assign oif.running              = enabled & {4{!pd_c}};
  assign oif.disable_level_select = dis_reg[1:0];

  cor_out_decode u_dec (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .o       (oif.drv)
  );

  // reference disable level: low, hiz, low, high for codes 00..11
  always_comb
  begin
    ctl_next[0] = !ref_output_enable;
    ctl_next[1] = (dis_reg[1:0] == 2'b11); // R9
    ctl_next[2] = (dis_reg[1:0] != 2'b01); // R9
    ctl_next[3] = pd_c;
    ctl_next[7:4] = 4'h0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ctl_reg <= 8'h04;
    else
      ctl_reg <= ctl_next;
  end

  assign ref_disabled = ctl_reg[0];
  assign ref_dis_lvl  = ctl_reg[1];
  assign ref_dis_oe   = ctl_reg[2];
  assign power_down   = ctl_reg[3];
  assign clk_true_lvl = oif.true_lvl;
  assign clk_true_oe  = oif.true_oe;
  assign clk_comp_lvl = oif.comp_lvl;
  assign clk_comp_oe  = oif.comp_oe;
  assign output_impedance_select = {imp23_reg[5:4], imp23_reg[3:2],
                                    imp01_reg[7:6], imp01_reg[3:2]}; // R2 R3
  assign enable_pin_pull_up   = {bias23_reg[5], bias23_reg[3], bias01_reg[7], bias01_reg[3]}; // R4 R5
  assign enable_pin_pull_down = {bias23_reg[4], bias23_reg[2], bias01_reg[6], bias01_reg[2]}; // R4 R5
  assign power_pin_pull_up    = pbias_reg[1]; // R6
  assign power_pin_pull_down  = pbias_reg[0]; // R6

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  rsvd_bits_zero_a: assert property ((dis_reg & ~8'h03) == 8'h00 && (enpol_reg & ~8'h6a) == 8'h00) // R10
    else $error("reserved bit stored");
  byte17_write_a: assert property ((wr_en && wr_ptr == 8'h11) |=> $stable(ppol_reg) && $stable(dis_reg)) // R10
    else $error("reserved byte write had an effect");
  imp_write_a: assert property ((wr_en && wr_ptr == 8'h0c) |=> imp01_reg == ($past(wr_data) & 8'hcc)) // R2
    else $error("impedance write lost");
  imp23_write_a: assert property ((wr_en && wr_ptr == 8'h0d) |=> imp23_reg[5:2] == $past(wr_data[5:2])) // R3
    else $error("impedance 2/3 write lost");
  bias_pin_a: assert property (enable_pin_pull_down[0] == bias01_reg[2] && enable_pin_pull_up[3] == bias23_reg[5]) // R4 R5
    else $error("enable pin bias miswired");
  pwr_bias_a: assert property ((wr_en && wr_ptr == 8'h10) |=> power_pin_pull_up == $past(wr_data[1])) // R6
    else $error("power pin bias write lost");
  en_polarity_a: assert property ((en_s[2] == enpol_reg[5] && !pd_c) |=> clk_true_oe[2] && clk_true_lvl[2]) // R7
    else $error("enabled output not running");
  pd_polarity_a: assert property ((pg_s == ppol_reg[0]) |=> power_down) // R8
    else $error("power down not entered");
  ref_hiz_a: assert property ((dis_reg[1:0] == 2'b01) |=> !ref_dis_oe) // R9
    else $error("reference not released in hiz code");
  ref_high_a: assert property ((dis_reg[1:0] == 2'b10) |=> ref_dis_oe && !ref_dis_lvl) // R9
    else $error("reference not low for high/low code");
endmodule : cor_regs

// *** testbench/cor_host.sv ***
// serial management host model driving the config bank's two pins
module cor_host #(
  parameter logic [6:0] ADDR = 7'h55
) (
  input  wire logic       ref_clk,
  input  wire logic       sda_line,
  output      logic       scl,
  output      logic       sda_low,
  output      logic [7:0] rd_data,
  output      logic       rd_done,
  output      int         nacks
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_data = 8'h00;
    rd_done = 1'b0;
    nacks = 0;
  end
  // each scl phase spans several ref_clk cycles so the slave's sync flops keep up
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : w
  // sda moves only mid-low, never mistaken for start or stop
  task automatic bit_io(input logic b, output logic s);
    scl = 1'b0;
    w(3);
    sda_low = ~b;
    w(5);
    scl = 1'b1;
    w(8);
    s = sda_line;
  endtask : bit_io
  // start and repeated start alike
  task automatic start();
    scl = 1'b0;
    w(3);
    sda_low = 1'b0;
    w(5);
    scl = 1'b1;
    w(8);
    sda_low = 1'b1;
    w(8);
  endtask : start
  task automatic stop();
    scl = 1'b0;
    w(3);
    sda_low = 1'b1;
    w(5);
    scl = 1'b1;
    w(8);
    sda_low = 1'b0;
    w(8);
  endtask : stop
  task automatic put_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask : put_byte
  // last byte of a read is answered with a nack to end it
  task automatic get_byte(input logic last);
    logic [7:0] d;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
    rd_data = d;
    rd_done = 1'b1;
    w(1);
    rd_done = 1'b0;
  endtask : get_byte
  task automatic write_regs(input logic [7:0] ofs, input logic [7:0] d[$]);
    start();
    put_byte({ADDR, 1'b0});
    put_byte(ofs);
    foreach (d[i]) put_byte(d[i]);
    stop();
  endtask : write_regs
  task automatic read_regs(input logic [7:0] ofs, input int n);
    start();
    put_byte({ADDR, 1'b0});
    put_byte(ofs);
    start();
    put_byte({ADDR, 1'b1});
    for (int i = 0; i < n; i++) get_byte(i == n - 1);
    stop();
  endtask : read_regs
endmodule : cor_host

// *** testbench/cor_regs_bench.sv ***
// self-checking bench for the clock output config bank
module cor_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 1'b0, rstn = 1'b0, scl, sda_low, sda_line, sda_out, sda_oe, rd_done;
  logic       ref_disabled, ref_dis_lvl, ref_dis_oe, power_down, ppu, ppd, pwr, refen;
  logic [3:0] tl, to, cl, co, pu, pd, en;
  logic [7:0] imp, rd_data, expq[$], wd[$];
  int         n_errors = 0, tests_run = 0, nacks, rnd;
  always #12.5 ref_clk = ~ref_clk;
  // open drain wire with pull-up
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out));
  cor_regs u_dut (.ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(en), .power_good_powerdown_pin(pwr),
    .ref_output_enable(refen), .clk_true_lvl(tl), .clk_true_oe(to), .clk_comp_lvl(cl),
    .clk_comp_oe(co), .ref_disabled(ref_disabled), .ref_dis_lvl(ref_dis_lvl),
    .ref_dis_oe(ref_dis_oe), .power_down(power_down), .output_impedance_select(imp),
    .enable_pin_pull_up(pu), .enable_pin_pull_down(pd), .power_pin_pull_up(ppu),
    .power_pin_pull_down(ppd));
  cor_host #(.ADDR(7'h55)) u_host (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low), .rd_data(rd_data), .rd_done(rd_done), .nacks(nacks));
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic settle();
    repeat (8) @(negedge ref_clk);
  endtask : settle
  // a read byte with no note left compares against x and so always counts
  always @(posedge ref_clk)
    if (rd_done === 1'b1)
      check("readback", rd_data, expq.size() ? expq.pop_front() : 8'hxx);
  // hang guard
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    stop_test();
  end
  initial
  begin
    rnd = $urandom(32'hed86);
    en = 4'h0;
    pwr = 1'b1;
    refen = 1'b1;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    settle();
    // defaults, byte 0x11 reads zero
    expq = '{8'h00, 8'h44, 8'h14, 8'h44, 8'h14, 8'h04, 8'h00, 8'h00, 8'h00};
    u_host.read_regs(8'h0b, 9);
    check("impedance", imp, 8'h55);
    check("bias", {pu, pd}, 8'h0f);
    $display("test defaults done");
    // random bytes everywhere; reserved bits must drop
    wd = {};
    for (int i = 0; i < 9; i++) wd.push_back(8'($urandom));
    u_host.write_regs(8'h0b, wd);
    expq = '{wd[0] & 8'h03, wd[1] & 8'hcc, wd[2] & 8'h3c, wd[3] & 8'hcc, wd[4] & 8'h3c,
             (wd[5] & 8'h03) | 8'h04, 8'h00, wd[7] & 8'h6a, wd[8] & 8'h01};
    u_host.read_regs(8'h0b, 9);
    check("impedance", imp, {wd[2][5:2], wd[1][7:6], wd[1][3:2]});
    check("bias", {pu, pd}, {wd[4][5], wd[4][3], wd[3][7], wd[3][3],
                             wd[4][4], wd[4][2], wd[3][6], wd[3][2]});
    check("power bias", {6'h0, ppu, ppd}, {6'h0, wd[5][1:0]});
    $display("test random fill done");
    // every disable code with all outputs and the reference disabled
    wd = {8'h00, 8'h00};
    u_host.write_regs(8'h12, wd);
    en = 4'hf;
    refen = 1'b0;
    for (int c = 0; c < 4; c++)
    begin
      wd = {8'(c)};
      u_host.write_regs(8'h0b, wd);
      settle();
      check("drive", {to, co}, (c == 1) ? 8'h00 : 8'hff);
      if (c != 1) check("levels", {tl, cl}, c == 2 ? 8'hf0 : c == 3 ? 8'h0f : 8'h00);
      check("ref", {5'h0, ref_disabled, ref_dis_oe, ref_dis_lvl & ref_dis_oe},
            c == 1 ? 8'h04 : c == 3 ? 8'h07 : 8'h06);
    end
    $display("test disable codes done");
    // enable pin polarity both ways
    en = 4'h0;
    settle();
    check("running", {tl, cl}, 8'hf0);
    wd = {8'h6a};
    u_host.write_regs(8'h12, wd);
    settle();
    check("stopped", {tl, cl}, 8'h0f);
    en = 4'hf;
    settle();
    check("running", {tl, cl}, 8'hf0);
    // power pin polarity both ways
    check("power down", {7'h0, power_down}, 8'h00);
    pwr = 1'b0;
    settle();
    check("power down", {7'h0, power_down}, 8'h01);
    wd = {8'h01};
    u_host.write_regs(8'h13, wd);
    settle();
    check("power down", {7'h0, power_down}, 8'h00);
    pwr = 1'b1;
    settle();
    check("power down", {7'h0, power_down}, 8'h01);
    check("acks", 8'(nacks), 8'h00);
    // a foreign address must draw no acknowledge; only the nack count is checked
    u_host.start();
    u_host.put_byte(8'h54); // address 7'h2a, write
    u_host.stop();
    check("foreign ack", 8'(nacks), 8'h01);
    $display("test polarity done");
    for (int k = 0; k < 100 && expq.size() > 0; k++) @(negedge ref_clk);
    if (expq.size() > 0) n_errors++;
    stop_test();
  end
endmodule : cor_regs_bench
